// >>> rtl/status_pkg.sv
// Purpose: constants for the instrument condition word block
// Assumes: 32-bit classic Wishbone register access
// Notes: register offsets are byte addresses
package status_pkg;
	localparam int WORD_W = 16;
	// field positions
	localparam int OP_LSB = 0;
	localparam int FLOW_DEV_BIT = 2;
	localparam int FLOW_HIST_BIT = 3;
	localparam int SRC_LSB = 4;
	localparam int CHAMBER_BIT = 6;
	localparam int TAPE_LSB = 7;
	localparam int VALVE_BIT = 9;
	localparam int TEST_LSB = 10;
	localparam int LINK_BIT = 13;
	localparam int CLEAN_BIT = 14;
	localparam int CARD_BIT = 15;
	// operation codes
	localparam logic [1:0] OP_MEASURE = 2'h0;
	localparam logic [1:0] OP_ADVANCE = 2'h1;
	localparam logic [1:0] OP_FIRST = 2'h2;
	localparam logic [1:0] OP_STOPPED = 2'h3;
	// tape codes
	localparam logic [1:0] TAPE_OK = 2'h0;
	localparam logic [1:0] TAPE_LOW = 2'h1;
	localparam logic [1:0] TAPE_LAST = 2'h2;
	localparam logic [1:0] TAPE_ERROR = 2'h3;
	// test codes
	localparam logic [2:0] TEST_NONE = 3'h0;
	localparam logic [2:0] TEST_STAB = 3'h1;
	localparam logic [2:0] TEST_CLEAN = 3'h2;
	localparam logic [2:0] TEST_TAPE = 3'h3;
	localparam logic [2:0] TEST_OPTIC = 3'h4;
	localparam logic [2:0] TEST_LEAK = 3'h6;
	// thresholds in millilitres per minute
	localparam int FLOW_W = 16;
	localparam logic [15:0] FLOW_TOL_ML = 16'h01f4;
	// ratio limits: ratio*20 compared with 4 and 15
	localparam int RATIO_DEN = 20;
	localparam int RATIO_LO = 4;
	localparam int RATIO_HI = 15;
	// spot counts
	localparam logic [7:0] SPOT_WARN = 8'h1e;
	localparam logic [7:0] SPOT_LAST = 8'h05;
	// led colours
	typedef enum logic [1:0] {
		LED_OFF = 2'b00,
		LED_GREEN = 2'b01,
		LED_YELLOW = 2'b10,
		LED_RED = 2'b11
	} led_colour_t;
	localparam int BLINK_HALF = 50000000;
	// register map
	localparam logic [3:0] ADDR_WORD = 4'h0;
	localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
	localparam logic [3:0] ADDR_IRQ_MASK = 4'h8;
	localparam logic [3:0] ADDR_CTRL = 4'hc;
	localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage

// >>> rtl/status_if.sv
`timescale 1ns/100ps
// Purpose: carries condition inputs to the word assembler
// Assumes: single clock
// Notes: filled by the top, read by the word assembler only
interface status_if;
	logic [1:0] op_code;
	logic flow_dev;
	logic flow_hist;
	logic [1:0] src_code;
	logic chamber_err;
	logic [1:0] tape_code;
	logic [2:0] test_code;
	logic link_err;
	logic clean_bad;
	logic card_err;
	modport source (output op_code, flow_dev, flow_hist, src_code,
		chamber_err, tape_code, test_code, link_err, clean_bad, card_err);
	modport sink (input op_code, flow_dev, flow_hist, src_code,
		chamber_err, tape_code, test_code, link_err, clean_bad, card_err);
endinterface // status_if

// >>> rtl/flow_judge.sv
`timescale 1ns/100ps
// Purpose: flags flow deviation from setpoint and sensor ratio
// Assumes: flows in millilitres per minute, signed
// Notes: combinational
module flow_judge #(
	parameter int FW = status_pkg::FLOW_W
) (
	// flows
	input wire logic signed [FW-1:0] setpoint_i,
	input wire logic signed [FW-1:0] first_sensor_flow_i,
	input wire logic signed [FW-1:0] second_sensor_flow_i,
	// verdict
	output logic deviate_o
);
	logic signed [FW+1:0] diff;
	logic signed [FW+7:0] f2_scaled;
	logic signed [FW+7:0] lo_lim;
	logic signed [FW+7:0] hi_lim;
	logic ratio_bad;
	always_comb begin
		diff = (FW+2)'(first_sensor_flow_i) - (FW+2)'(setpoint_i);
		f2_scaled = (FW+8)'(second_sensor_flow_i) *
			(FW+8)'(status_pkg::RATIO_DEN);
		lo_lim = (FW+8)'(first_sensor_flow_i) * (FW+8)'(status_pkg::RATIO_LO);
		hi_lim = (FW+8)'(first_sensor_flow_i) * (FW+8)'(status_pkg::RATIO_HI);
		ratio_bad = (f2_scaled < lo_lim) || (f2_scaled > hi_lim);
		deviate_o = (diff > (FW+2)'(signed'({2'b00, status_pkg::FLOW_TOL_ML})))
			|| (diff < -(FW+2)'(signed'({2'b00, status_pkg::FLOW_TOL_ML})))
			|| (first_sensor_flow_i < 0)
			|| ratio_bad;
	end
endmodule // flow_judge

// >>> rtl/condition_word.sv
`timescale 1ns/100ps
// Purpose: instrument condition word with Wishbone access and interrupt
// Assumes: subsystem inputs synchronous to clk_i
// Notes: word registered each edge, zero at reset
// Contract
// - status is one 16-bit word, each field on its own bits.
// - bits 1:0 hold operation: measure, advance, first, stopped.
// - bit 2 set on flow deviation, negative first flow, bad ratio.
// - bit 3 requests history check; both bits may be set together.
// - bits 5:4 hold optical source state codes.
// - bit 6 high on chamber error.
// - bits 8:7 hold tape state from spots left and motion.
// - bit 9 is reserved for the ball valve.
// - bits 12:10 hold the running test code.
// - bit 13 link error; bit 14 clean-air result unacceptable.
// - bit 15 set on storage card failure.
// - stopped indication only when word equals 3.
// - data qualified unless operation nonzero or test active.
// - green at 0, blinking green when word equals 1.
// - yellow while running with tape warning 128.
module condition_word #(
	parameter int BLINK_HALF = status_pkg::BLINK_HALF
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// subsystem conditions
	input wire logic [1:0] op_code_i,
	input wire logic signed [15:0] flow_setpoint_i,
	input wire logic signed [15:0] first_sensor_flow_i,
	input wire logic signed [15:0] second_sensor_flow_i,
	input wire logic flow_hist_i,
	input wire logic [1:0] src_code_i,
	input wire logic chamber_err_i,
	input wire logic [7:0] spots_left_i,
	input wire logic tape_stuck_i,
	input wire logic [2:0] test_code_i,
	input wire logic link_err_i,
	input wire logic clean_bad_i,
	input wire logic card_err_i,
	// outputs
	output logic [15:0] word_o,
	output logic stopped_o,
	output logic record_ok_o,
	output logic [1:0] led_o,
	output logic irq_o
);
	status_if cond ();
	logic [15:0] word_reg;
	logic [15:0] word_next;
	logic [15:0] prev_reg;
	logic [15:0] irq_stat_reg;
	logic [15:0] irq_mask_reg;
	logic blink_en_reg;
	logic [31:0] blink_cnt_reg;
	logic blink_reg;
	logic ack_reg;
	logic [31:0] dat_reg;
	logic flow_dev;
	logic [1:0] tape_code;
	logic acc;
	logic wr;
	logic [15:0] events;
	logic stopped_reg;
	logic record_ok_reg;
	logic [1:0] led_reg;

	// ----------------------------------------
	// condition gathering
	// ----------------------------------------
	flow_judge #(.FW(status_pkg::FLOW_W)) judge (
		.setpoint_i(flow_setpoint_i),
		.first_sensor_flow_i(first_sensor_flow_i),
		.second_sensor_flow_i(second_sensor_flow_i),
		.deviate_o(flow_dev)
	);

	always_comb begin
		if (tape_stuck_i) begin
			tape_code = status_pkg::TAPE_ERROR;
		end else if (spots_left_i < status_pkg::SPOT_LAST) begin
			tape_code = status_pkg::TAPE_LAST;
		end else if (spots_left_i < status_pkg::SPOT_WARN) begin
			tape_code = status_pkg::TAPE_LOW;
		end else begin
			tape_code = status_pkg::TAPE_OK;
		end
	end

	function automatic logic [2:0] legal_test(input logic [2:0] t);
		unique case (t)
			status_pkg::TEST_NONE, status_pkg::TEST_STAB,
			status_pkg::TEST_CLEAN, status_pkg::TEST_TAPE,
			status_pkg::TEST_OPTIC, status_pkg::TEST_LEAK: legal_test = t;
			default: legal_test = status_pkg::TEST_NONE;
		endcase
	endfunction

	assign cond.op_code = op_code_i;
	assign cond.flow_dev = flow_dev;
	assign cond.flow_hist = flow_hist_i;
	assign cond.src_code = src_code_i;
	assign cond.chamber_err = chamber_err_i;
	assign cond.tape_code = tape_code;
	assign cond.test_code = legal_test(test_code_i);
	assign cond.link_err = link_err_i;
	assign cond.clean_bad = clean_bad_i;
	assign cond.card_err = card_err_i;

	// ----------------------------------------
	// word assembly
	// ----------------------------------------
	word_pack pack (
		.cond(cond),
		.word_o(word_next)
	);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			word_reg <= status_pkg::WORD_RESET;
			prev_reg <= status_pkg::WORD_RESET;
		end else begin
			word_reg <= word_next;
			prev_reg <= word_reg;
		end
	end
	assign word_o = word_reg;

	// ----------------------------------------
	// derived indications
	// ----------------------------------------
	function automatic logic [1:0] led_colour(input logic [15:0] w,
		input logic blink);
		if (w == status_pkg::WORD_RESET) begin
			led_colour = status_pkg::LED_GREEN;
		end else if (w == 16'(status_pkg::OP_ADVANCE)) begin
			led_colour = blink ? status_pkg::LED_GREEN : status_pkg::LED_OFF;
		end else if (w == 16'(status_pkg::OP_STOPPED)) begin
			led_colour = status_pkg::LED_RED;
		end else begin
			led_colour = status_pkg::LED_YELLOW;
		end
	endfunction

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			stopped_reg <= 1'b0;
			record_ok_reg <= 1'b1;
			led_reg <= status_pkg::LED_GREEN;
		end else begin
			stopped_reg <= (word_next == 16'(status_pkg::OP_STOPPED));
			record_ok_reg <=
				(word_next[status_pkg::OP_LSB +: 2] == status_pkg::OP_MEASURE) &&
				(word_next[status_pkg::TEST_LSB +: 3] == status_pkg::TEST_NONE);
			led_reg <= led_colour(word_next, blink_reg);
		end
	end
	assign stopped_o = stopped_reg;
	assign record_ok_o = record_ok_reg;
	assign led_o = led_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= 1'b1;
		end else if (!blink_en_reg ||
			blink_cnt_reg == 32'(BLINK_HALF - 1)) begin
			blink_cnt_reg <= 32'h0;
			blink_reg <= blink_en_reg ? ~blink_reg : 1'b1;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 32'h1;
		end
	end

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	assign acc = cyc_i && stb_i && !ack_reg;
	assign wr = acc && we_i && sel_i[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0;
		end else begin
			ack_reg <= acc;
			unique case (adr_i)
				status_pkg::ADDR_WORD: dat_reg <= {16'h0, word_reg};
				status_pkg::ADDR_IRQ_STAT: dat_reg <= {16'h0, irq_stat_reg};
				status_pkg::ADDR_IRQ_MASK: dat_reg <= {16'h0, irq_mask_reg};
				status_pkg::ADDR_CTRL: dat_reg <= {31'h0, blink_en_reg};
				default: dat_reg <= 32'h0;
			endcase
		end
	end
	assign ack_o = ack_reg;
	assign dat_o = dat_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			blink_en_reg <= 1'b1;
		end else if (wr && adr_i == status_pkg::ADDR_CTRL) begin
			blink_en_reg <= dat_i[0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_mask_reg <= 16'h0;
		end else if (wr && adr_i == status_pkg::ADDR_IRQ_MASK) begin
			irq_mask_reg[7:0] <= dat_i[7:0];
			if (sel_i[1]) begin
				irq_mask_reg[15:8] <= dat_i[15:8];
			end
		end
	end

	// ----------------------------------------
	// interrupt: bits rising in the word
	// ----------------------------------------
	assign events = word_reg & ~prev_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_stat_reg <= 16'h0;
		end else if (wr && adr_i == status_pkg::ADDR_IRQ_STAT) begin
			irq_stat_reg <= (irq_stat_reg &
				~{sel_i[1] ? dat_i[15:8] : 8'h0, dat_i[7:0]}) | events;
		end else begin
			irq_stat_reg <= irq_stat_reg | events;
		end
	end
	assign irq_o = |(irq_stat_reg & irq_mask_reg);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property stop_only_p;
		@(posedge clk_i) disable iff (rst_i)
		stopped_o |-> word_o == 16'(status_pkg::OP_STOPPED);
	endproperty
	stop_only_a: assert property (stop_only_p)
		else $error("stopped with other word");
	property op_field_p;
		@(posedge clk_i) disable iff (rst_i)
		##1 word_o[1:0] == $past(op_code_i);
	endproperty
	op_field_a: assert property (op_field_p)
		else $error("operation field wrong");
	property chamber_bit_p;
		@(posedge clk_i) disable iff (rst_i)
		##1 word_o[6] == $past(chamber_err_i);
	endproperty
	chamber_bit_a: assert property (chamber_bit_p)
		else $error("chamber bit wrong");
	property valve_zero_p;
		@(posedge clk_i) disable iff (rst_i)
		word_o[9] == 1'b0;
	endproperty
	valve_zero_a: assert property (valve_zero_p)
		else $error("valve bit set");
	property test_legal_p;
		@(posedge clk_i) disable iff (rst_i)
		word_o[12:10] != 3'h5 && word_o[12:10] != 3'h7;
	endproperty
	test_legal_a: assert property (test_legal_p)
		else $error("illegal test code");
	property record_gate_p;
		@(posedge clk_i) disable iff (rst_i)
		(word_o[1:0] != 2'h0 || word_o[12:10] != 3'h0) |-> !record_ok_o;
	endproperty
	record_gate_a: assert property (record_gate_p)
		else $error("recording while busy");
	property tape_warn_p;
		@(posedge clk_i) disable iff (rst_i)
		word_o == 16'h0080 |-> led_o == status_pkg::LED_YELLOW;
	endproperty
	tape_warn_a: assert property (tape_warn_p)
		else $error("tape warning not yellow");
	property green_idle_p;
		@(posedge clk_i) disable iff (rst_i)
		word_o == 16'h0000 |-> led_o == status_pkg::LED_GREEN;
	endproperty
	green_idle_a: assert property (green_idle_p)
		else $error("idle not green");
	property card_bit_p;
		@(posedge clk_i) disable iff (rst_i)
		card_err_i |=> word_o[15];
	endproperty
	card_bit_a: assert property (card_bit_p)
		else $error("card bit missing");
	property link_bits_p;
		@(posedge clk_i) disable iff (rst_i)
		##1 word_o[14:13] == {$past(clean_bad_i), $past(link_err_i)};
	endproperty
	link_bits_a: assert property (link_bits_p)
		else $error("link or clean bit wrong");
	property hist_bit_p;
		@(posedge clk_i) disable iff (rst_i)
		##1 word_o[3] == $past(flow_hist_i);
	endproperty
	hist_bit_a: assert property (hist_bit_p)
		else $error("history bit wrong");
	property src_field_p;
		@(posedge clk_i) disable iff (rst_i)
		##1 word_o[5:4] == $past(src_code_i);
	endproperty
	src_field_a: assert property (src_field_p)
		else $error("source field wrong");
	property tape_end_p;
		@(posedge clk_i) disable iff (rst_i)
		tape_stuck_i |=> word_o[8:7] == status_pkg::TAPE_ERROR;
	endproperty
	tape_end_a: assert property (tape_end_p)
		else $error("tape error missing");
	property neg_flow_p;
		@(posedge clk_i) disable iff (rst_i)
		first_sensor_flow_i < 0 |=> word_o[2];
	endproperty
	neg_flow_a: assert property (neg_flow_p)
		else $error("negative flow not flagged");
	property irq_sticky_p;
		@(posedge clk_i) disable iff (rst_i)
		events != 16'h0 |=> (irq_stat_reg & $past(events)) == $past(events);
	endproperty
	irq_sticky_a: assert property (irq_sticky_p)
		else $error("event lost by status");
	sequence word_req_s;
		cyc_i && stb_i && !we_i && !ack_o && adr_i == status_pkg::ADDR_WORD;
	endsequence
	sequence word_ans_s;
		ack_o && dat_o == {16'h0, $past(word_o)};
	endsequence
	property word_read_p;
		@(posedge clk_i) disable iff (rst_i)
		word_req_s |=> word_ans_s;
	endproperty
	word_read_a: assert property (word_read_p)
		else $error("word read wrong");
	property stop_code_p;
		@(posedge clk_i) disable iff (rst_i)
		word_o == 16'h0003 |-> stopped_o && led_o == status_pkg::LED_RED;
	endproperty
	stop_code_a: assert property (stop_code_p)
		else $error("word 3 not shown as stopped");
endmodule // condition_word

// >>> rtl/word_pack.sv
`timescale 1ns/100ps
// Purpose: places each condition code on its own bits of the word
// Assumes: codes already legal
// Notes: valve bit held at zero
module word_pack (
	// conditions
	status_if.sink cond,
	// word
	output logic [15:0] word_o
);
	always_comb begin
		word_o = status_pkg::WORD_RESET;
		word_o[status_pkg::OP_LSB +: 2] = cond.op_code;
		word_o[status_pkg::FLOW_DEV_BIT] = cond.flow_dev;
		word_o[status_pkg::FLOW_HIST_BIT] = cond.flow_hist;
		word_o[status_pkg::SRC_LSB +: 2] = cond.src_code;
		word_o[status_pkg::CHAMBER_BIT] = cond.chamber_err;
		word_o[status_pkg::TAPE_LSB +: 2] = cond.tape_code;
		word_o[status_pkg::VALVE_BIT] = 1'b0;
		word_o[status_pkg::TEST_LSB +: 3] = cond.test_code;
		word_o[status_pkg::LINK_BIT] = cond.link_err;
		word_o[status_pkg::CLEAN_BIT] = cond.clean_bad;
		word_o[status_pkg::CARD_BIT] = cond.card_err;
	end
endmodule // word_pack

// >>> verification/subsys_model.sv
`timescale 1ns/100ps
// Purpose: subsystem monitors feeding condition codes to the block
// Assumes: codes change only just after a rising clock edge
// Notes: a commanded vector is reported one edge later
module subsys_model (
	// clock
	input wire logic clk_i,
	// commanded conditions
	input wire logic [68:0] scen_i,
	// reported conditions
	output logic [68:0] cond_o
);
	// ------
	// report
	// ------
	always_ff @(posedge clk_i) begin
		cond_o <= scen_i;
	end
endmodule // subsys_model

// >>> verification/instrument_status_word_tb.sv
`timescale 1ns/100ps
// Purpose: self-checking bench for the condition word block
// Assumes: word readable at byte address 0 over classic wishbone
// Notes: blink half period shortened to 4 cycles
module instrument_status_word_tb;
	typedef struct {
		logic [31:0] d;
		logic [15:0] w;
		logic irq;
		bit ck_irq;
	} exp_t;
	localparam logic [68:0] BASE = {2'h0, 16'd1000, 16'd1000, 16'd500,
		4'h0, 8'd100, 7'h00};
	localparam logic [47:0] FT [7] = '{{16'd1500, 16'd1000, 16'd500},
		{16'd1501, 16'd1000, 16'd500}, {16'd1000, 16'hffff, 16'd0},
		{16'd1000, 16'd1000, 16'd200}, {16'd1000, 16'd1000, 16'd199},
		{16'd1000, 16'd1000, 16'd750}, {16'd1000, 16'd1000, 16'd751}};
	localparam logic [7:0] SP [4] = '{8'd30, 8'd29, 8'd5, 8'd4};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] adr_i = 4'h0;
	logic [3:0] sel_i = 4'hf;
	logic [31:0] dat_i = 32'h0;
	logic [31:0] dat_o;
	logic ack_o;
	logic [15:0] word_o;
	logic stopped_o;
	logic record_ok_o;
	logic irq_o;
	logic [1:0] led_o;
	logic [68:0] scen = BASE;
	logic [68:0] cond;
	logic [15:0] cur_w = 16'h0;
	exp_t q[$];
	int errors = 0;
	int cmp_count = 0;

	always #5 clk_i = ~clk_i;

	subsys_model i_subsys_model (.clk_i(clk_i), .scen_i(scen), .cond_o(cond));

	condition_word #(.BLINK_HALF(4)) i_condition_word (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
		.we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
		.dat_o(dat_o), .ack_o(ack_o), .op_code_i(cond[68:67]),
		.flow_setpoint_i(cond[66:51]), .first_sensor_flow_i(cond[50:35]),
		.second_sensor_flow_i(cond[34:19]), .flow_hist_i(cond[18]),
		.src_code_i(cond[17:16]), .chamber_err_i(cond[15]),
		.spots_left_i(cond[14:7]), .tape_stuck_i(cond[6]),
		.test_code_i(cond[5:3]), .link_err_i(cond[2]),
		.clean_bad_i(cond[1]), .card_err_i(cond[0]), .word_o(word_o),
		.stopped_o(stopped_o), .record_ok_o(record_ok_o), .led_o(led_o),
		.irq_o(irq_o));

	// ---------------
	// expected values
	// ---------------
	function automatic logic [15:0] calc(input logic [68:0] v);
		int s;
		int a;
		int b;
		logic dev;
		logic [1:0] tp;
		logic [2:0] t;
		s = $signed(v[66:51]);
		a = $signed(v[50:35]);
		b = $signed(v[34:19]);
		dev = (s - a > 500) || (a - s > 500) || (a < 0) ||
			(b * 20 < a * 4) || (b * 20 > a * 15);
		tp = v[6] ? 2'h3 : (v[14:7] < 8'd5) ? 2'h2 :
			(v[14:7] < 8'd30) ? 2'h1 : 2'h0;
		t = (v[5:3] == 3'h5 || v[5:3] == 3'h7) ? 3'h0 : v[5:3];
		return {v[0], v[1], v[2], t, 1'b0, tp, v[15], v[17:16], v[18], dev,
			v[68:67]};
	endfunction

	function automatic logic [1:0] led_of(input logic [15:0] w);
		if (w == 16'h0000) return status_pkg::LED_GREEN;
		if (w == 16'h0003) return status_pkg::LED_RED;
		return status_pkg::LED_YELLOW;
	endfunction

	// -----
	// tasks
	// -----
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic complete_run();
		$display("comparisons %0d errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (ack_o !== 1'b1) begin
			errors++;
			$display("[FAIL] %0t no acknowledge", $time);
			complete_run();
		end
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
	endtask

	task automatic rd(input logic [3:0] a, input logic [31:0] d,
		input logic irq, input bit ck);
		q.push_back('{d, cur_w, irq, ck});
		wb(a, 1'b0, 32'h0);
	endtask

	task automatic apply(input logic [68:0] v);
		@(posedge clk_i);
		scen <= v;
		cur_w = calc(v);
		repeat (3) @(posedge clk_i);
		rd(status_pkg::ADDR_WORD, {16'h0, cur_w}, 1'b0, 1'b0);
	endtask

	// -------
	// monitor
	// -------
	always @(posedge clk_i) begin
		exp_t e;
		if (ack_o === 1'b1 && we_i === 1'b0) begin
			if (q.size() == 0) begin
				errors++;
				$display("[FAIL] %0t unexpected read answer", $time);
			end else begin
				e = q.pop_front();
				check(dat_o, e.d);
				check({16'h0, word_o}, {16'h0, e.w});
				check({31'h0, stopped_o}, {31'h0, e.w == 16'h3});
				check({31'h0, record_ok_o},
					{31'h0, e.w[1:0] == 2'h0 && e.w[12:10] == 3'h0});
				if (e.w != 16'h1) begin
					check({30'h0, led_o}, {30'h0, led_of(e.w)});
				end
				if (e.ck_irq) check({31'h0, irq_o}, {31'h0, e.irq});
			end
		end
	end

	// ---------
	// sequences
	// ---------
	initial begin
		logic [68:0] v;
		int a;
		void'($urandom(72));
		repeat (3) @(posedge clk_i);
		check({16'h0, word_o}, 32'h0);
		rst_i <= 1'b0;
		rd(status_pkg::ADDR_CTRL, 32'h1, 1'b0, 1'b0);
		rd(status_pkg::ADDR_IRQ_MASK, 32'h0, 1'b0, 1'b0);
		wb(status_pkg::ADDR_IRQ_STAT, 1'b1, 32'hffff);
		wb(status_pkg::ADDR_IRQ_MASK, 1'b1, 32'hffff);
		rd(status_pkg::ADDR_IRQ_MASK, 32'hffff, 1'b0, 1'b0);
		v = BASE;
		v[0] = 1'b1;
		apply(v);
		rd(status_pkg::ADDR_IRQ_STAT, 32'h8000, 1'b1, 1'b1);
		wb(status_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0);
		rd(status_pkg::ADDR_IRQ_STAT, 32'h8000, 1'b0, 1'b1);
		wb(status_pkg::ADDR_IRQ_STAT, 1'b1, 32'h8000);
		rd(status_pkg::ADDR_IRQ_STAT, 32'h0, 1'b0, 1'b1);
		rd(4'h2, 32'h0, 1'b0, 1'b0);
		wb(status_pkg::ADDR_WORD, 1'b1, 32'hffff);
		rd(status_pkg::ADDR_WORD, {16'h0, cur_w}, 1'b0, 1'b0);
		for (int i = 0; i < 8; i++) begin
			v = BASE;
			v[5:3] = 3'(i);
			apply(v);
		end
		for (int i = 0; i < 4; i++) begin
			v = BASE;
			v[68:67] = 2'(i);
			apply(v);
			v = BASE;
			v[14:7] = SP[i];
			apply(v);
		end
		v = BASE;
		v[6] = 1'b1;
		apply(v);
		for (int i = 0; i < 7; i++) begin
			v = BASE;
			v[66:19] = FT[i];
			v[18] = i[0];
			apply(v);
		end
		for (int i = 0; i < 19; i++) begin
			if (i < 3 || i > 14) begin
				v = BASE;
				v[i] = 1'b1;
				apply(v);
			end
		end
		v = BASE;
		v[68:67] = 2'h1;
		apply(v);
		for (int k = 1; k >= 0; k--) begin
			wb(status_pkg::ADDR_CTRL, 1'b1, 32'(k));
			rd(status_pkg::ADDR_CTRL, 32'(k), 1'b0, 1'b0);
			a = 0;
			repeat (24) begin
				@(posedge clk_i);
				if (led_o === status_pkg::LED_GREEN) a++;
			end
			check(32'(a), k ? 32'd12 : 32'd24);
		end
		for (int i = 0; i < 40; i++) begin
			v = BASE;
			v[68:67] = 2'($urandom);
			v[66:51] = 16'(800 + $urandom % 600);
			v[50:35] = 16'(int'($urandom % 3000) - 200);
			v[34:19] = 16'($urandom % 2500);
			v[18:0] = 19'($urandom);
			v[14:7] = 8'($urandom % 64);
			apply(v);
		end
		complete_run();
	end
endmodule // instrument_status_word_tb
